//--- pkg/sci_pkg.sv
// Constants and types for the control-input front end of the DRAM.
// Assumes a single 100 MHz clock domain (mclk) and synchronous reset.
//
// Overview of operation
// [R01] Address and control inputs are captured only on the rising edge of the clock.
// [R02] Clock gate low runs internal clock, input buffers and drivers; high turns them off.
// [R03] Raising the clock gate with all banks idle gives precharge power-down or self refresh, else active power-down.
// [R04] The clock gate is evaluated on clock edges for power-down entry and exit and self refresh entry.
// [R05] Self refresh exit and output turn-off follow the clock gate without waiting for a clock edge; here both are registered on mclk.
// [R06] The controller keeps the clock gate low throughout every read and write access.
// [R07] In power-down all input buffers are off except the clocks and the clock gate.
// [R08] In self refresh every input buffer is off, clocks included, except the clock gate.
// [R09] Chip select registered low enables the command decoder; registered high masks the command.
// [R10] The command comes from chip select and the row, column and write strobes sampled together.
// [R11] A write data beat whose mask is sampled high with it is left unwritten.
// [R12] The write mask is sampled on both edges of the write data strobe.
// [R13] The write mask pin also carries the read bus inversion flag during reads.
// [R14] The read data strobe pin carries the write inversion flag, driven by the controller; the front end has no input for it.
// [R15] The bank select inputs choose the bank for activate, read, write and precharge.
// [R16] A power-state register tracks the clock gate and bank idle status and drives buffer enables.
package sci_pkg;

  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 13;
  localparam int LANES = 4;
  localparam int AP_BIT = 8; // Auto precharge / all-banks address bit

  // Decoded command set
  typedef enum logic [3:0] {
    SCI_CMD_NOP, SCI_CMD_ACT, SCI_CMD_RD, SCI_CMD_WR, SCI_CMD_PRE,
    SCI_CMD_REF, SCI_CMD_MRS, SCI_CMD_RSV
  } sci_cmd_t;

  // Power states
  typedef enum logic [1:0] {
    SCI_PS_ACTIVE, SCI_PS_ACT_PD, SCI_PS_PRE_PD, SCI_PS_SELF_REF
  } sci_pwr_t;

endpackage : sci_pkg

//--- core/sci_mask_lane.sv
// Write mask sampler for one byte lane, both edges of its write data strobe.
// Assumes the strobe is already synchronised to mclk as a level.
`timescale 1ns/1ps
module sci_mask_lane
  import sci_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Synchronised lane inputs
  input wire logic strobe_s,
  input wire logic mask_s,
  input wire logic wr_en,
  // Result
  output logic beat_pulse_q,
  output logic beat_masked_q
);

  logic strobe_q;

  // Edge detect on the synchronised strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= strobe_s;
    end
  end

  // Sample mask on rising and falling edge alike
  always_ff @(posedge mclk) begin
    if (rst) begin
      beat_pulse_q <= 1'b0;
      beat_masked_q <= 1'b0;
    end else begin
      beat_pulse_q <= wr_en && (strobe_s != strobe_q); // see [R12]
      beat_masked_q <= wr_en && (strobe_s != strobe_q) && mask_s; // see [R11]
    end
  end

endmodule : sci_mask_lane

//--- core/sci_front_end.sv
// Control-input front end: command capture, power states, write mask lanes.
// Assumes pins arrive asynchronously and are synchronised here on mclk.
`timescale 1ns/1ps
module sci_front_end
  import sci_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Command pins
  input wire logic clk_gate_n,
  input wire logic chip_sel_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic wr_strobe_n,
  input wire logic [BANK_W-1:0] bank_select,
  input wire logic [ADDR_W-1:0] addr,
  // Data-side pins
  input wire logic [LANES-1:0] write_data_strobe,
  input wire logic [LANES-1:0] write_mask_i,
  input wire logic read_dbi_en,
  input wire logic [LANES-1:0] read_flag,
  // Mask pin in read inversion use
  output logic [LANES-1:0] write_mask_o,
  output logic [LANES-1:0] write_mask_oe_n,
  // Decoded command
  output sci_cmd_t cmd_q,
  output logic cmd_valid_q,
  output logic [BANK_W-1:0] cmd_bank_q,
  output logic [ADDR_W-1:0] cmd_addr_q,
  // Power and buffer control
  output sci_pwr_t pwr_state_q,
  output logic int_clk_en_q,
  output logic in_buf_en_q,
  output logic clk_buf_en_q,
  output logic out_drv_en_q,
  output logic [NUM_BANKS-1:0] bank_open_q,
  // Write beats
  output logic [LANES-1:0] beat_pulse_q,
  output logic [LANES-1:0] beat_masked_q
);

  ////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [1:0] gate_sync_q;
  logic [1:0] cs_sync_q, ras_sync_q, cas_sync_q, we_sync_q;
  logic [BANK_W-1:0] ba_sync1_q, ba_sync2_q;
  logic [ADDR_W-1:0] ad_sync1_q, ad_sync2_q;
  logic [LANES-1:0] dqs_sync1_q, dqs_sync2_q, dm_sync1_q, dm_sync2_q;
  logic [LANES-1:0] rf_sync1_q, rf_sync2_q;
  logic rdbi_sync1_q, rdbi_sync2_q;
  logic gate_s;
  logic wr_active_q, rd_active_q;

  // Two stages before any logic reads a pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      gate_sync_q <= 2'h0; // Idle running level, so no false power-down after reset
      cs_sync_q <= 2'h3;
      ras_sync_q <= 2'h3;
      cas_sync_q <= 2'h3;
      we_sync_q <= 2'h3;
      ba_sync1_q <= '0;
      ba_sync2_q <= '0;
      ad_sync1_q <= '0;
      ad_sync2_q <= '0;
      dqs_sync1_q <= '0;
      dqs_sync2_q <= '0;
      dm_sync1_q <= '0;
      dm_sync2_q <= '0;
      rf_sync1_q <= '0;
      rf_sync2_q <= '0;
      rdbi_sync1_q <= 1'b0;
      rdbi_sync2_q <= 1'b0;
    end else begin
      gate_sync_q <= {gate_sync_q[0], clk_gate_n};
      cs_sync_q <= {cs_sync_q[0], chip_sel_n};
      ras_sync_q <= {ras_sync_q[0], row_strobe_n};
      cas_sync_q <= {cas_sync_q[0], col_strobe_n};
      we_sync_q <= {we_sync_q[0], wr_strobe_n};
      ba_sync1_q <= bank_select;
      ba_sync2_q <= ba_sync1_q;
      ad_sync1_q <= addr;
      ad_sync2_q <= ad_sync1_q;
      dqs_sync1_q <= write_data_strobe;
      dqs_sync2_q <= dqs_sync1_q;
      dm_sync1_q <= write_mask_i;
      dm_sync2_q <= dm_sync1_q;
      rf_sync1_q <= read_flag;
      rf_sync2_q <= rf_sync1_q;
      rdbi_sync1_q <= read_dbi_en;
      rdbi_sync2_q <= rdbi_sync1_q;
    end
  end

  assign gate_s = gate_sync_q[1];

  ////////////////////////////////////////////////////////////////////
  // Command decode

  sci_cmd_t cmd_d;

  // Strobe pattern to command, chip select high masks all
  always_comb begin
    unique case ({ras_sync_q[1], cas_sync_q[1], we_sync_q[1]}) // see [R10]
      3'h7: cmd_d = SCI_CMD_NOP;
      3'h3: cmd_d = SCI_CMD_ACT;
      3'h5: cmd_d = SCI_CMD_RD;
      3'h4: cmd_d = SCI_CMD_WR;
      3'h2: cmd_d = SCI_CMD_PRE;
      3'h1: cmd_d = SCI_CMD_REF;
      3'h0: cmd_d = SCI_CMD_MRS;
      3'h6: cmd_d = SCI_CMD_RSV;
    endcase
  end

  // Capture on mclk rising edge only; command only while awake, bank and address every cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_q <= SCI_CMD_NOP;
      cmd_valid_q <= 1'b0;
      cmd_bank_q <= '0;
      cmd_addr_q <= '0;
    end else begin
      cmd_valid_q <= in_buf_en_q && !cs_sync_q[1] && (cmd_d != SCI_CMD_NOP); // see [R09]
      cmd_q <= (in_buf_en_q && !cs_sync_q[1]) ? cmd_d : SCI_CMD_NOP; // see [R01]
      cmd_bank_q <= ba_sync2_q; // see [R15]
      cmd_addr_q <= ad_sync2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bank tracking

  // Activate opens, precharge closes one bank or all
  always_ff @(posedge mclk) begin
    if (rst) begin
      bank_open_q <= '0;
    end else if (cmd_valid_q && cmd_q == SCI_CMD_ACT) begin
      bank_open_q[cmd_bank_q] <= 1'b1; // see [R15]
    end else if (cmd_valid_q && cmd_q == SCI_CMD_PRE) begin
      if (cmd_addr_q[AP_BIT]) begin
        bank_open_q <= '0;
      end else begin
        bank_open_q[cmd_bank_q] <= 1'b0;
      end
    end
  end

  // Access in flight, kept until the next command or until the gate goes high
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_active_q <= 1'b0;
      rd_active_q <= 1'b0;
    end else if (cmd_valid_q) begin
      wr_active_q <= (cmd_q == SCI_CMD_WR);
      rd_active_q <= (cmd_q == SCI_CMD_RD);
    end else if (gate_s) begin
      // Controller must keep the gate low during accesses
      wr_active_q <= 1'b0; // see [R06]
      rd_active_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power state

  // Gate high picks a low-power state from bank status; refresh gives self refresh
  always_ff @(posedge mclk) begin
    if (rst) begin
      pwr_state_q <= SCI_PS_ACTIVE;
    end else begin
      unique case (pwr_state_q)
        SCI_PS_ACTIVE: begin
          if (gate_s) begin // see [R04]
            if (|bank_open_q) begin
              pwr_state_q <= SCI_PS_ACT_PD; // see [R03]
            end else if (cmd_valid_q && cmd_q == SCI_CMD_REF) begin
              pwr_state_q <= SCI_PS_SELF_REF; // see [R03]
            end else begin
              pwr_state_q <= SCI_PS_PRE_PD; // see [R03]
            end
          end
        end
        SCI_PS_ACT_PD, SCI_PS_PRE_PD, SCI_PS_SELF_REF: begin
          if (!gate_s) begin
            pwr_state_q <= SCI_PS_ACTIVE; // see [R16]
          end
        end
      endcase
    end
  end

  // Clock buffer enable follows state; internal clock, input buffers and drivers are taken from the gate directly
  always_ff @(posedge mclk) begin
    if (rst) begin
      int_clk_en_q <= 1'b1;
      in_buf_en_q <= 1'b1;
      clk_buf_en_q <= 1'b1;
      out_drv_en_q <= 1'b1;
    end else begin
      // Gate high drops clock and drivers at once, no state wait
      int_clk_en_q <= !gate_s; // see [R02]
      out_drv_en_q <= !gate_s; // see [R05]
      // Self refresh exit needs no command edge, only the gate
      in_buf_en_q <= !gate_s && (pwr_state_q == SCI_PS_ACTIVE || !gate_s); // see [R07]
      clk_buf_en_q <= (pwr_state_q != SCI_PS_SELF_REF) || !gate_s; // see [R08]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mask pin and write beats

  // Mask pin drives the read inversion flag only during reads
  always_ff @(posedge mclk) begin
    if (rst) begin
      write_mask_o <= '0;
      write_mask_oe_n <= '1;
    end else begin
      write_mask_o <= rf_sync2_q; // see [R13]
      write_mask_oe_n <= {LANES{!(rd_active_q && rdbi_sync2_q && !gate_s)}};
    end
  end

  // One sampler per byte lane
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    sci_mask_lane u_lane (
      .mclk(mclk),
      .rst(rst),
      .strobe_s(dqs_sync2_q[g]),
      .mask_s(dm_sync2_q[g]),
      .wr_en(wr_active_q),
      .beat_pulse_q(beat_pulse_q[g]),
      .beat_masked_q(beat_masked_q[g])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  property p_cs_masks;
    @(posedge mclk) disable iff (rst)
      cs_sync_q[1] |=> !cmd_valid_q;
  endproperty
  a_cs_masks: assert property (p_cs_masks) else $error("command taken with select high"); // see [R09]

  property p_gate_off;
    @(posedge mclk) disable iff (rst)
      gate_s |=> !int_clk_en_q && !out_drv_en_q;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("clock or drivers on with gate high"); // see [R02]

  property p_act_pd;
    @(posedge mclk) disable iff (rst)
      (pwr_state_q == SCI_PS_ACTIVE && gate_s && |bank_open_q) |=> pwr_state_q == SCI_PS_ACT_PD;
  endproperty
  a_act_pd: assert property (p_act_pd) else $error("no active power-down with open row"); // see [R03]

  property p_pre_pd;
    @(posedge mclk) disable iff (rst)
      (pwr_state_q == SCI_PS_ACTIVE && gate_s && !(|bank_open_q))
        |=> pwr_state_q inside {SCI_PS_PRE_PD, SCI_PS_SELF_REF};
  endproperty
  a_pre_pd: assert property (p_pre_pd) else $error("wrong idle power-down state"); // see [R04]

  property p_pd_inbuf;
    @(posedge mclk) disable iff (rst)
      (pwr_state_q != SCI_PS_ACTIVE && gate_s) |=> !in_buf_en_q;
  endproperty
  a_pd_inbuf: assert property (p_pd_inbuf) else $error("input buffers on in power-down"); // see [R07]

  property p_sr_clkbuf;
    @(posedge mclk) disable iff (rst)
      (pwr_state_q == SCI_PS_SELF_REF && gate_s) |=> !clk_buf_en_q;
  endproperty
  a_sr_clkbuf: assert property (p_sr_clkbuf) else $error("clock buffers on in self refresh"); // see [R08]

  property p_sr_exit;
    @(posedge mclk) disable iff (rst)
      (pwr_state_q == SCI_PS_SELF_REF && !gate_s) |=> pwr_state_q == SCI_PS_ACTIVE && out_drv_en_q;
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit not immediate"); // see [R05]

  property p_act_open;
    @(posedge mclk) disable iff (rst)
      (cmd_valid_q && cmd_q == SCI_CMD_ACT) |=> bank_open_q[$past(cmd_bank_q)];
  endproperty
  a_act_open: assert property (p_act_open) else $error("activate did not open bank"); // see [R15]

  property p_decode;
    @(posedge mclk) disable iff (rst)
      (in_buf_en_q && !cs_sync_q[1] && {ras_sync_q[1], cas_sync_q[1], we_sync_q[1]} == 3'h4)
        |=> cmd_valid_q && cmd_q == SCI_CMD_WR;
  endproperty
  a_decode: assert property (p_decode) else $error("write strobes not decoded"); // see [R10]

  property p_mask_beat;
    @(posedge mclk) disable iff (rst)
      beat_masked_q[0] |-> beat_pulse_q[0];
  endproperty
  a_mask_beat: assert property (p_mask_beat) else $error("masked flag without beat"); // see [R11]

endmodule : sci_front_end

//--- bench/sci_ctrl_model.sv
// Controller model: drives command, address and write lane pins.
// Assumes the bench calls its tasks; pins move only at rising mclk.
`timescale 1ns/1ps
module sci_ctrl_model
  import sci_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Command pins
  output logic clk_gate_n,
  output logic chip_sel_n,
  output logic [2:0] rcw_n,
  output logic [BANK_W-1:0] bank_select,
  output logic [ADDR_W-1:0] addr,
  // Write lanes
  output logic [LANES-1:0] write_data_strobe,
  output logic [LANES-1:0] write_mask_i,
  // Write inversion flag on the read strobe pin
  output logic [LANES-1:0] read_data_strobe
);
  // Idle pins at time zero: deselected, row, column and write strobes high
  initial begin
    clk_gate_n = 1'b0;
    chip_sel_n = 1'b1;
    rcw_n = 3'h7;
    bank_select = 3'h0;
    addr = 13'h0000;
    write_data_strobe = 4'h0;
    write_mask_i = 4'h0;
    read_data_strobe = 4'h0;
  end
  ////////////////////////////////////////
  // Command held n cycles, then NOP; gate pin not driven meanwhile
  task cmd(input logic cs, input logic [2:0] c, input logic [2:0] b,
           input logic [12:0] a, input int n);
    @(posedge mclk);
    chip_sel_n <= cs;
    rcw_n <= c;
    bank_select <= b;
    addr <= a;
    repeat (n) @(posedge mclk);
    chip_sel_n <= 1'b1;
    rcw_n <= 3'h7;
    bank_select <= ~b; // Stale address is not left on the pins
    addr <= ~a;
  endtask : cmd
  // Clock gate level change
  task gate(input logic v);
    @(posedge mclk);
    clk_gate_n <= v;
  endtask : gate
  // One strobe edge with its mask, spaced 3 cycles; mask marks beats masked
  task beat(input logic [3:0] m);
    @(posedge mclk);
    write_data_strobe <= ~write_data_strobe;
    write_mask_i <= m;
    read_data_strobe <= 4'h0; // Write data sent plain, flag low
    repeat (2) @(posedge mclk);
  endtask : beat
endmodule : sci_ctrl_model

//--- bench/tb.sv
// Self-checking bench for the control-input front end.
// Assumes sci_ctrl_model stands on the pin side; one 100 MHz clock.
`timescale 1ns/1ps
module tb
  import sci_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic read_dbi_en = 1'b0;
  logic [3:0] read_flag = 4'h0;
  wire logic gn, csn;
  wire logic [2:0] rcw, bs, cb;
  wire logic [12:0] ad, ca;
  wire logic [3:0] wds, wmi, wmo, wmoe_n, bp, bm, rds;
  sci_cmd_t cmd;
  sci_pwr_t ps;
  wire logic cv, ice, ibe, cbe, ode;
  wire logic [7:0] bo;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int nb[4] = '{0, 0, 0, 0};
  int nm[4] = '{0, 0, 0, 0};
  int sb[4];
  int sm[4];
  logic [2:0] code[7] = '{3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0, 3'h6};
  sci_cmd_t ex[7] = '{SCI_CMD_ACT, SCI_CMD_RD, SCI_CMD_WR, SCI_CMD_PRE,
                      SCI_CMD_REF, SCI_CMD_MRS, SCI_CMD_RSV};
  int em[4] = '{2, 2, 1, 1};
  logic [3:0] mp[4] = '{4'h5, 4'hA, 4'h3, 4'h0};

  sci_ctrl_model ctl (.mclk(mclk), .clk_gate_n(gn), .chip_sel_n(csn), .rcw_n(rcw),
    .bank_select(bs), .addr(ad), .write_data_strobe(wds), .write_mask_i(wmi),
    .read_data_strobe(rds));
  sci_front_end dut (.mclk(mclk), .rst(rst), .clk_gate_n(gn), .chip_sel_n(csn),
    .row_strobe_n(rcw[2]), .col_strobe_n(rcw[1]), .wr_strobe_n(rcw[0]),
    .bank_select(bs), .addr(ad), .write_data_strobe(wds), .write_mask_i(wmi),
    .read_dbi_en(read_dbi_en), .read_flag(read_flag), .write_mask_o(wmo),
    .write_mask_oe_n(wmoe_n), .cmd_q(cmd), .cmd_valid_q(cv), .cmd_bank_q(cb),
    .cmd_addr_q(ca), .pwr_state_q(ps), .int_clk_en_q(ice), .in_buf_en_q(ibe),
    .clk_buf_en_q(cbe), .out_drv_en_q(ode), .bank_open_q(bo),
    .beat_pulse_q(bp), .beat_masked_q(bm));
  ////////////////////////////////////////
  // Clock, beat counters and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      nb[i] <= nb[i] + bp[i];
      nm[i] <= nm[i] + bm[i];
    end
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total = err_total + 1;
      results();
    end
  end
  ////////////////////////////////////////
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // Seven non-NOP encodings on banks 0 to 6 with their addresses, one-cycle pulse at c3
  task t_decode();
    for (int i = 0; i < 7; i++) begin
      ctl.cmd(1'b0, code[i], i[2:0], 13'h0100 + 13'(i), 1);
      repeat (2) @(posedge mclk);
      #1;
      chk(cv, 1);
      chk(cmd, ex[i]);
      chk(cb, i);
      chk(ca, 13'h0100 + 13'(i));
      @(posedge mclk);
      #1;
      chk(cv, 0);
    end
    $display("test decode done");
  endtask : t_decode
  // Deselected read and selected NOP are both dropped
  task t_cs();
    for (int i = 0; i < 2; i++) begin
      ctl.cmd(i[0] ? 1'b0 : 1'b1, i[0] ? 3'h7 : 3'h5, 3'h1, 13'h0001, 1);
      repeat (2) @(posedge mclk);
      #1;
      chk(cv, 0);
    end
    $display("test cs done");
  endtask : t_cs
  task pwr(input logic v, input sci_pwr_t e, input logic [3:0] en);
    ctl.gate(v);
    repeat (3) @(posedge mclk);
    #1;
    chk(ps, e);
    chk({ice, ibe, cbe, ode}, en);
  endtask : pwr
  // Active, precharge power-down and self refresh round trips
  task t_power();
    ctl.cmd(1'b0, 3'h3, 3'h5, 13'h0000, 1);
    repeat (3) @(posedge mclk);
    #1;
    chk(bo, 8'h20);
    pwr(1'b1, SCI_PS_ACT_PD, 4'h2);
    ctl.cmd(1'b0, 3'h5, 3'h5, 13'h0000, 1);
    repeat (2) @(posedge mclk);
    #1;
    chk(cv, 0);
    pwr(1'b0, SCI_PS_ACTIVE, 4'hF);
    // Second bank opened, then a single-bank precharge must spare it
    ctl.cmd(1'b0, 3'h3, 3'h1, 13'h0000, 1);
    ctl.cmd(1'b0, 3'h2, 3'h5, 13'h0000, 1);
    repeat (3) @(posedge mclk);
    #1;
    chk(bo, 8'h02);
    ctl.cmd(1'b0, 3'h2, 3'h0, 13'h0100, 1);
    repeat (3) @(posedge mclk);
    #1;
    chk(bo, 8'h00);
    pwr(1'b1, SCI_PS_PRE_PD, 4'h2);
    pwr(1'b0, SCI_PS_ACTIVE, 4'hF);
    fork
      ctl.cmd(1'b0, 3'h1, 3'h0, 13'h0000, 4);
      begin
        @(posedge mclk);
        ctl.gate(1'b1);
      end
    join
    repeat (2) @(posedge mclk);
    #1;
    chk(ps, SCI_PS_SELF_REF);
    chk({ice, ibe, cbe, ode}, 4'h0);
    pwr(1'b0, SCI_PS_ACTIVE, 4'hF);
    $display("test power done");
  endtask : t_power
  // Four strobe edges with mixed masks on every lane
  task t_write();
    ctl.cmd(1'b0, 3'h4, 3'h2, 13'h0000, 1);
    repeat (3) @(posedge mclk);
    sb = nb;
    sm = nm;
    for (int k = 0; k < 4; k++) ctl.beat(mp[k]);
    repeat (4) @(posedge mclk);
    #1;
    for (int i = 0; i < 4; i++) begin
      chk(nb[i] - sb[i], 4);
      chk(nm[i] - sm[i], em[i]);
    end
    chk(wmoe_n, 4'hF);
    $display("test write done");
  endtask : t_write
  // Read inversion flag driven out on the mask pin, then released
  task t_flag();
    @(posedge mclk);
    read_flag <= 4'hA;
    read_dbi_en <= 1'b1;
    ctl.cmd(1'b0, 3'h5, 3'h2, 13'h0000, 1);
    repeat (5) @(posedge mclk);
    #1;
    chk(wmoe_n, 4'h0);
    chk(wmo, 4'hA);
    // Strobe edges outside a write give no beats
    sb = nb;
    ctl.beat(4'hF);
    repeat (4) @(posedge mclk);
    #1;
    chk(nb[0] - sb[0], 0);
    @(posedge mclk);
    read_dbi_en <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk(wmoe_n, 4'hF);
    $display("test flag done");
  endtask : t_flag
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_decode();
    t_cs();
    t_power();
    t_write();
    t_flag();
    results();
  end
endmodule : tb
